// ==== usb_core_irq_source_mask.v ====
// Functional notes
// - Endpoint bits 12..9 latch receive events of endpoints 4..1.
// - Endpoint bits 4..1 latch transmit events of endpoints 4..1.
// - Endpoint bit 0 latches combined receive/transmit of control endpoint 0.
// - Core register holds nine core sources in 8..0; 15..9 read zero.
// - Writing one to force-endpoint bit sets that endpoint source.
// - Writing one to force-core bits 8..0 sets that core source.
// - Reading force or ack registers returns current source contents.
// - Writing one to ack-endpoint bit clears that endpoint source.
// - Writing one to ack-core bits 8..0 clears that core source.
// - Masks gate only pending view; raw sources always latch.
// - Each enable bit sits in its source's bit position.
// - Enable registers read-only, reset zero, changed via on/off registers.
// - Writing one to enable-on bit sets that enable; set means enabled.
// - Writing one to enable-off bit clears that enable bit.
// - Reading enable-on or enable-off registers returns current enables.
// - Pending registers show source AND enable, same positions.
// - Only core-raised interrupts are covered; no DMA events.
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "usb_irq_map.vh"

module usb_core_irq_source_mask #(
  parameter EP_COUNT = 4,
  parameter CORE_EVENTS = 9
) (
  input wire clock,
  input wire rstn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [EP_COUNT-1:0] receive_ep_irq,
  input wire [EP_COUNT-1:0] transmit_ep_irq,
  input wire control_ep0_irq,
  input wire [CORE_EVENTS-1:0] core_event_irq,
  output reg irq
);

  // ****************************************************************
  // Register bus
  // ****************************************************************
  wire wr_strobe;
  wire [11:0] wr_addr;
  wire [15:0] wr_data;
  wire rd_strobe;
  wire [11:0] rd_addr;
  reg [15:0] rd_data;
  reg rd_hit;
  reg wr_hit;

  axil_reg_port u_port (
    .clock(clock),
    .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_strobe(wr_strobe),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_hit(wr_hit),
    .rd_strobe(rd_strobe),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  // ****************************************************************
  // Write decode
  // ****************************************************************
  function [15:0] wr_sel;
    input strobe;
    input [11:0] addr;
    input [11:0] target;
    input [15:0] data;
    begin
      wr_sel = (strobe && addr == target) ? data : 16'h0000;
    end
  endfunction

  wire [15:0] force_ep = wr_sel(wr_strobe, wr_addr, `OFS_FORCE_EP, wr_data);
  wire [15:0] force_core = wr_sel(wr_strobe, wr_addr, `OFS_FORCE_CORE, wr_data);
  wire [15:0] ack_ep = wr_sel(wr_strobe, wr_addr, `OFS_ACK_EP, wr_data);
  wire [15:0] ack_core = wr_sel(wr_strobe, wr_addr, `OFS_ACK_CORE, wr_data);
  wire [15:0] on_ep = wr_sel(wr_strobe, wr_addr, `OFS_EN_ON_EP, wr_data);
  wire [15:0] on_core = wr_sel(wr_strobe, wr_addr, `OFS_EN_ON_CORE, wr_data);
  wire [15:0] off_ep = wr_sel(wr_strobe, wr_addr, `OFS_EN_OFF_EP, wr_data);
  wire [15:0] off_core = wr_sel(wr_strobe, wr_addr, `OFS_EN_OFF_CORE, wr_data);

  // Read-only registers accept writes silently; unmapped offsets answer SLVERR
  always @* begin
    if (wr_addr == `OFS_RAW_EP || wr_addr == `OFS_RAW_CORE) begin
      wr_hit = 1'b1;
    end else if (wr_addr == `OFS_EN_EP || wr_addr == `OFS_EN_CORE) begin
      wr_hit = 1'b1;
    end else if (wr_addr == `OFS_PEND_EP || wr_addr == `OFS_PEND_CORE) begin
      wr_hit = 1'b1;
    end else if (wr_addr >= `OFS_FORCE_EP && wr_addr <= `OFS_ACK_CORE
                 && wr_addr[1:0] == 2'h0) begin
      wr_hit = 1'b1;
    end else if (wr_addr >= `OFS_EN_ON_EP && wr_addr <= `OFS_EN_OFF_CORE
                 && wr_addr[1:0] == 2'h0) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // ****************************************************************
  // Hardware event mapping into the endpoint register layout
  // ****************************************************************
  reg [15:0] ep_events;
  always @* begin
    ep_events = 16'h0000;
    ep_events[`EP_RX_MSB:`EP_RX_LSB] = receive_ep_irq[3:0];
    ep_events[`EP_TX_MSB:`EP_TX_LSB] = transmit_ep_irq[3:0];
    ep_events[`EP_CTRL0_BIT] = control_ep0_irq;
  end

  wire [15:0] core_events = {{(16 - CORE_EVENTS){1'b0}}, core_event_irq};

  // ****************************************************************
  // Source and enable flags
  // ****************************************************************
  wire [15:0] raw_ep;
  wire [15:0] raw_core;
  wire [15:0] en_ep;
  wire [15:0] en_core;

  // Sources latch regardless of enables; set beats clear
  irq_bit_cell #(.WIDTH(16), .VALID(`EP_VALID_MASK)) u_raw_ep (
    .clock(clock),
    .rstn(rstn),
    .set_bits(ep_events | force_ep),
    .clear_bits(ack_ep),
    .value(raw_ep)
  );

  irq_bit_cell #(.WIDTH(16), .VALID(`CORE_VALID_MASK)) u_raw_core (
    .clock(clock),
    .rstn(rstn),
    .set_bits(core_events | force_core),
    .clear_bits(ack_core),
    .value(raw_core)
  );

  // Same layout as sources, reset to zero
  irq_bit_cell #(.WIDTH(16), .VALID(`EP_VALID_MASK)) u_en_ep (
    .clock(clock),
    .rstn(rstn),
    .set_bits(on_ep),
    .clear_bits(off_ep),
    .value(en_ep)
  );

  irq_bit_cell #(.WIDTH(16), .VALID(`CORE_VALID_MASK)) u_en_core (
    .clock(clock),
    .rstn(rstn),
    .set_bits(on_core),
    .clear_bits(off_core),
    .value(en_core)
  );

  // Only core events feed these flags, no DMA inputs exist
  wire [15:0] pend_ep = raw_ep & en_ep;
  wire [15:0] pend_core = raw_core & en_core;

  // ****************************************************************
  // Interrupt output
  // ****************************************************************
  always @(posedge clock) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |{pend_ep, pend_core};
    end
  end

  // ****************************************************************
  // Read decode
  // ****************************************************************
  // Valid masks in the cells keep reserved bits zero
  always @* begin
    rd_hit = 1'b1;
    if (rd_addr == `OFS_RAW_EP) begin
      rd_data = raw_ep;
    end else if (rd_addr == `OFS_RAW_CORE) begin
      rd_data = raw_core;
    end else if (rd_addr == `OFS_FORCE_EP || rd_addr == `OFS_ACK_EP) begin
      rd_data = raw_ep;
    end else if (rd_addr == `OFS_FORCE_CORE || rd_addr == `OFS_ACK_CORE) begin
      rd_data = raw_core;
    end else if (rd_addr == `OFS_EN_EP) begin
      rd_data = en_ep;
    end else if (rd_addr == `OFS_EN_CORE) begin
      rd_data = en_core;
    end else if (rd_addr == `OFS_EN_ON_EP || rd_addr == `OFS_EN_OFF_EP) begin
      rd_data = en_ep;
    end else if (rd_addr == `OFS_EN_ON_CORE || rd_addr == `OFS_EN_OFF_CORE) begin
      rd_data = en_core;
    end else if (rd_addr == `OFS_PEND_EP) begin
      rd_data = pend_ep;
    end else if (rd_addr == `OFS_PEND_CORE) begin
      rd_data = pend_core;
    end else begin
      rd_data = 16'h0000;
      rd_hit = 1'b0;
    end
  end

endmodule // usb_core_irq_source_mask

// ==== usb_irq_map.vh ====
`ifndef USB_IRQ_MAP_VH
`define USB_IRQ_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_RAW_EP 12'h000
`define OFS_RAW_CORE 12'h004
`define OFS_FORCE_EP 12'h008
`define OFS_FORCE_CORE 12'h00C
`define OFS_ACK_EP 12'h010
`define OFS_ACK_CORE 12'h014
`define OFS_EN_EP 12'h018
`define OFS_EN_CORE 12'h01C
`define OFS_EN_ON_EP 12'h020
`define OFS_EN_ON_CORE 12'h024
`define OFS_EN_OFF_EP 12'h028
`define OFS_EN_OFF_CORE 12'h02C
`define OFS_PEND_EP 12'h030
`define OFS_PEND_CORE 12'h034

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define EP_CTRL0_BIT 0
`define EP_TX_LSB 1
`define EP_TX_MSB 4
`define EP_RX_LSB 9
`define EP_RX_MSB 12
`define EP_VALID_MASK 16'h1E1F
`define CORE_VALID_MASK 16'h01FF
`define IRQ_RESET 16'h0000
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// ==== irq_bit_cell.v ====
`timescale 1ns/1ps
// ****************************************************************
// Bank of set/clear flags; a set wins over a clear in the same cycle
// ****************************************************************
module irq_bit_cell #(
  parameter WIDTH = 16,
  parameter [15:0] VALID = 16'hFFFF
) (
  input wire clock,
  input wire rstn,
  input wire [WIDTH-1:0] set_bits,
  input wire [WIDTH-1:0] clear_bits,
  output reg [WIDTH-1:0] value
);
  always @(posedge clock) begin
    if (!rstn) begin
      value <= {WIDTH{1'b0}};
    end else begin
      value <= ((value & ~clear_bits) | set_bits) & VALID[WIDTH-1:0];
    end
  end
endmodule // irq_bit_cell

// ==== axil_reg_port.v ====
`timescale 1ns/1ps
`include "usb_irq_map.vh"
// ****************************************************************
// AXI4-Lite slave: one write and one read at a time, one-cycle strobes out
// ****************************************************************
module axil_reg_port (
  input wire clock,
  input wire rstn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output wire wr_strobe,
  output wire [11:0] wr_addr,
  output wire [15:0] wr_data,
  input wire wr_hit,
  output wire rd_strobe,
  output wire [11:0] rd_addr,
  input wire [15:0] rd_data,
  input wire rd_hit
);
  reg aw_held;
  reg w_held;
  reg [11:0] aw_addr;
  reg [15:0] w_data;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_strobe = aw_held && w_held;
  assign wr_addr = aw_addr;
  assign wr_data = w_data;
  assign rd_strobe = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;

  always @(posedge clock) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 16'h0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        // Registers are 16 bits; lanes 2 and 3 are ignored
        w_data <= {s_axi_wstrb[1] ? s_axi_wdata[15:8] : 8'h00,
                   s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00};
      end
      if (wr_strobe) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge clock) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `AXI_RESP_OKAY;
    end else if (rd_strobe) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_data};
      s_axi_rresp <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // axil_reg_port

// ==== usb_irq_checker_asserts.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Bus handshake and interrupt output checks
// ****************************************************************
module usb_irq_checker (
  input wire clock,
  input wire rstn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_aw_refused; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_aw_refused: assert property (p_aw_refused) else $error("write taken during response");
  property p_ar_refused; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_refused: assert property (p_ar_refused) else $error("read taken during response");
  property p_read_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");
  property p_rdata_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data dropped");
  property p_upper_zero; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper lanes not zero");
  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer late");
  property p_bvalid_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write answer dropped");
  property p_irq_sticky; irq && !s_axi_bvalid |=> irq; endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("irq fell with no write");
  property p_resp_code; s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2; endproperty
  a_resp_code: assert property (p_resp_code) else $error("bad write response");
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_write: cover property (s_axi_bvalid && s_axi_bresp == 2'h0);
endmodule // usb_irq_checker

bind usb_core_irq_source_mask usb_irq_checker chk_i (.clock(clock), .rstn(rstn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .irq(irq));

// ==== core_event_model.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Core event sources, one output cycle per request cycle
// ****************************************************************
module core_event_model (
  input wire clock,
  input wire rstn,
  input wire [17:0] request,
  output reg [3:0] receive_ep_irq,
  output reg [3:0] transmit_ep_irq,
  output reg control_ep0_irq,
  output reg [8:0] core_event_irq
);
  always @(posedge clock) begin
    if (!rstn) begin
      {core_event_irq, receive_ep_irq, transmit_ep_irq, control_ep0_irq} <= 18'h00000;
    end else begin
      {core_event_irq, receive_ep_irq, transmit_ep_irq, control_ep0_irq} <= request;
    end
  end
endmodule // core_event_model

// ==== testbench.sv ====
`timescale 1ns/1ps
`include "usb_irq_map.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  reg clock, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg [11:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata;
  reg [3:0] s_axi_wstrb;
  reg [17:0] request;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, ctrl0;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] rx, tx;
  wire [8:0] core;
  reg [15:0] ep, co;
  int fails = 0, compares = 0, k;
  usb_core_irq_source_mask usb_core_irq_source_mask_i (.clock(clock), .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .receive_ep_irq(rx),
    .transmit_ep_irq(tx), .control_ep0_irq(ctrl0), .core_event_irq(core), .irq(irq));
  core_event_model core_event_model_i (.clock(clock), .rstn(rstn), .request(request),
    .receive_ep_irq(rx), .transmit_ep_irq(tx), .control_ep0_irq(ctrl0), .core_event_irq(core));
  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic wr(input [11:0] a, input [15:0] d, input [1:0] er);
    reg aw_done, w_done;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      aw_done = 1'b0;
      w_done = 1'b0;
      while (!(aw_done && w_done)) begin
        @(posedge clock);
        if (s_axi_awvalid && s_axi_awready) begin
          aw_done = 1'b1;
          s_axi_awvalid <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_done = 1'b1;
          s_axi_wvalid <= 1'b0;
        end
      end
      do @(posedge clock); while (!s_axi_bvalid);
      `CHK(s_axi_bresp, er)
    end
  endtask
  task automatic rd(input [11:0] a, input [15:0] e, input [1:0] er);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clock); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clock); while (!s_axi_rvalid);
      `CHK(s_axi_rdata, {16'h0000, e})
      `CHK(s_axi_rresp, er)
    end
  endtask
  task stop_test;
    begin
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask
  // ****************************************************************
  // Clock, watchdog and tests
  // ****************************************************************
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    stop_test;
  end
  initial begin
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, request} = 74'h0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    for (k = 0; k < 14; k++) rd(12'(k * 4), 16'h0000, 2'h0);
    rd(12'h038, 16'h0000, 2'h2);
    wr(12'h038, 16'hFFFF, 2'h2);
    for (k = 0; k < 18; k++) begin
      ep = (k < 5) ? (16'h0001 << k) : (k < 9) ? (16'h0001 << (k + 4)) : 16'h0000;
      co = (k < 9) ? 16'h0000 : (16'h0001 << (k - 9));
      request <= 18'h00001 << k;
      @(posedge clock);
      request <= 18'h00000;
      repeat (3) @(posedge clock);
      rd(`OFS_RAW_EP, ep, 2'h0);
      rd(`OFS_FORCE_CORE, co, 2'h0);
      rd(`OFS_ACK_EP, ep, 2'h0);
      wr(`OFS_ACK_CORE, 16'h0000, 2'h0);
      rd(`OFS_RAW_CORE, co, 2'h0);
      wr(`OFS_ACK_EP, ep, 2'h0);
      wr(`OFS_ACK_CORE, co, 2'h0);
      rd(`OFS_RAW_EP, 16'h0000, 2'h0);
      rd(`OFS_RAW_CORE, 16'h0000, 2'h0);
    end
    wr(`OFS_FORCE_EP, 16'hFFFF, 2'h0);
    wr(`OFS_FORCE_CORE, 16'hFFFF, 2'h0);
    rd(`OFS_RAW_EP, 16'h1E1F, 2'h0);
    rd(`OFS_RAW_CORE, 16'h01FF, 2'h0);
    rd(`OFS_PEND_EP, 16'h0000, 2'h0);
    `CHK(irq, 1'b0)
    wr(`OFS_EN_EP, 16'hFFFF, 2'h0);
    rd(`OFS_EN_EP, 16'h0000, 2'h0);
    wr(`OFS_EN_ON_EP, 16'h0200, 2'h0);
    rd(`OFS_EN_OFF_EP, 16'h0200, 2'h0);
    rd(`OFS_PEND_EP, 16'h0200, 2'h0);
    `CHK(irq, 1'b1)
    wr(`OFS_EN_ON_CORE, 16'hFFFF, 2'h0);
    rd(`OFS_EN_ON_CORE, 16'h01FF, 2'h0);
    wr(`OFS_EN_OFF_EP, 16'h0200, 2'h0);
    rd(`OFS_EN_EP, 16'h0000, 2'h0);
    wr(`OFS_ACK_CORE, 16'h01FE, 2'h0);
    rd(`OFS_PEND_CORE, 16'h0001, 2'h0);
    request <= 18'h00200;
    repeat (3) @(posedge clock);
    wr(`OFS_ACK_CORE, 16'h0001, 2'h0);
    rd(`OFS_RAW_CORE, 16'h0001, 2'h0);
    request <= 18'h00000;
    repeat (3) @(posedge clock);
    wr(`OFS_ACK_CORE, 16'h0001, 2'h0);
    rd(`OFS_PEND_CORE, 16'h0000, 2'h0);
    `CHK(irq, 1'b0)
    s_axi_wstrb <= 4'h2;
    wr(`OFS_ACK_EP, 16'hFFFF, 2'h0);
    rd(`OFS_RAW_EP, 16'h001F, 2'h0);
    s_axi_wstrb <= 4'hF;
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    rd(`OFS_RAW_EP, 16'h0000, 2'h0);
    rd(`OFS_EN_CORE, 16'h0000, 2'h0);
    `CHK(irq, 1'b0)
    stop_test;
  end
endmodule // testbench
